// [src/card_bridge_params.svh]
// constants of the card bridge system configuration registers
`ifndef CARD_BRIDGE_PARAMS_SVH
`define CARD_BRIDGE_PARAMS_SVH

// configuration offsets, same in functions 0 and 1
`define LEGACY_BASE_OFFSET     8'h44
`define SYS_CTRL_OFFSET        8'h80

// reset values
`define LEGACY_BASE_RESET      32'h0000_0001
`define SYS_CTRL_RESET         32'h0044_9060
`define SYS_CTRL_LOW_FIXED     16'h9060

// system control field positions
`define IRQ_SLOT_SHIFT_HI      31
`define IRQ_SLOT_SHIFT_LO      30
`define MERGE_INT_LINES_BIT    29
`define SWITCH_CLOCK_DIR_BIT   27
`define POWER_EVENT_ROUTE_BIT  26
`define POWER_WRITE_FLAG_BIT   25
`define POWER_WRITE_IRQ_EN_BIT 24
`define SPARE_TERM_DRIVE_BIT   22
`define SUPPLY_GUARD_OFF_BIT   21
`define REDUCED_VIDEO_BIT      20
`define CARD_DMA_REQ_EN_BIT    19
`define DMA_CHANNEL_HI         18
`define DMA_CHANNEL_LO         16

// dma channel code meaning bus master, never forwarded
`define DMA_CHANNEL_UNUSED     3'h4

`endif

// [src/card_bridge_pkg.sv]
// types shared by the card bridge system configuration logic
`default_nettype none

package card_bridge_pkg;

   // serialized interrupt slot stepping codes
   typedef enum logic [1:0] {
      STEP_B_C   = 2'h0,
      STEP_C_D   = 2'h1,
      STEP_C_D_2 = 2'h2,
      STEP_D_A   = 2'h3
   } slot_step_e;

   // configuration function number, one per socket
   typedef logic [0:0] cfg_func_t;

endpackage : card_bridge_pkg
`default_nettype wire

// [src/card_bridge_system_config.sv]
// system configuration registers of the dual-socket card bridge
`timescale 1ns/1ps
`default_nettype none
`include "card_bridge_params.svh"

module card_bridge_system_config
   import card_bridge_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   // configuration access port
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_write_i,
   input  wire cfg_func_t   cfg_func_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_byte_en_i,
   input  wire logic [31:0] cfg_wdata_i,
   output var  logic        cfg_ack_o,
   output var  logic [31:0] cfg_rdata_o,
   // legacy index/data decode
   input  wire logic        io_valid_i,
   input  wire logic [31:0] io_addr_i,
   output var  logic        legacy_index_hit_o,
   output var  logic        legacy_data_hit_o,
   // socket power write events
   input  wire logic [1:0]  power_write_i,
   output var  logic        legacy_irq2_o,
   output var  logic [1:0]  card_status_change_o,
   // internal interrupts onto the serialized stream
   input  wire logic        int_a_i,
   input  wire logic        int_b_i,
   output var  logic [3:0]  serial_irq_line_o,
   // socket pins and controls
   input  wire logic [1:0]  card_inserted_i,
   input  wire logic [1:0]  card_dma_request_i,
   output var  logic        switch_clock_oe_n_o,
   output var  logic [1:0]  spare_terminals_oe_n_o,
   output var  logic [1:0]  supply_guard_en_o,
   output var  logic        card_addr_hi_oe_n_o,
   output var  logic [1:0]  dma_request_o,
   output var  logic [2:0]  dma_channel_sel_o
);

   // register state, shared unless per socket
   logic [31:1] legacy_base_reg,      legacy_base_next;
   logic [1:0]  irq_slot_shift_reg,   irq_slot_shift_next;
   logic        merge_int_lines_reg,  merge_int_lines_next;
   logic        switch_clock_dir_reg, switch_clock_dir_next;
   logic        power_event_route_reg, power_event_route_next;
   logic        power_write_irq_en_reg, power_write_irq_en_next;
   logic        spare_terminal_drive_reg, spare_terminal_drive_next;
   logic        reduced_video_reg,    reduced_video_next;
   logic        card_dma_req_en_reg,  card_dma_req_en_next;
   logic [2:0]  dma_channel_sel_reg,  dma_channel_sel_next;
   logic [1:0]  supply_guard_off_reg, supply_guard_off_next;
   logic [1:0]  power_write_flag_reg, power_write_flag_next;

   // access port answer
   logic        cfg_ack_reg,  cfg_ack_next;
   logic [31:0] cfg_rdata_reg, cfg_rdata_next;

   // pin synchronisers
   logic [1:0]  inserted_meta_reg, inserted_sync_reg;
   logic [1:0]  request_meta_reg,  request_sync_reg;

   // output flops
   logic        index_hit_reg,   index_hit_next;
   logic        data_hit_reg,    data_hit_next;
   logic        irq2_reg,        irq2_next;
   logic [1:0]  change_reg,      change_next;
   logic [3:0]  serial_irq_reg,  serial_irq_next;
   logic        clock_oe_n_reg,  clock_oe_n_next;
   logic [1:0]  spare_oe_n_reg,  spare_oe_n_next;
   logic [1:0]  guard_en_reg,    guard_en_next;
   logic        addr_oe_n_reg,   addr_oe_n_next;
   logic [1:0]  dma_req_reg,     dma_req_next;
   logic [2:0]  dma_chan_out_reg, dma_chan_out_next;

   // decoded access
   logic        hit_base;
   logic        hit_ctrl;
   logic        wr_base;
   logic        wr_ctrl;
   logic [31:0] ctrl_view;
   logic [31:0] index_addr;
   logic [31:0] data_addr;
   slot_step_e  step;

   assign hit_base = (cfg_addr_i == `LEGACY_BASE_OFFSET);
   assign hit_ctrl = (cfg_addr_i == `SYS_CTRL_OFFSET);
   // same decode whatever the function number; base storage is shared, per-socket control bits follow the function
   assign wr_base  = cfg_req_i & cfg_write_i & hit_base;
   assign wr_ctrl  = cfg_req_i & cfg_write_i & hit_ctrl;
   assign step     = slot_step_e'(irq_slot_shift_reg);

   // read view of system control; per-socket bits follow the function
   always_comb begin
      ctrl_view = {irq_slot_shift_reg,
                   merge_int_lines_reg,
                   1'b0,
                   switch_clock_dir_reg,
                   power_event_route_reg,
                   power_write_flag_reg[cfg_func_i],
                   power_write_irq_en_reg,
                   1'b0,
                   spare_terminal_drive_reg,
                   supply_guard_off_reg[cfg_func_i],
                   reduced_video_reg,
                   card_dma_req_en_reg,
                   dma_channel_sel_reg,
                   `SYS_CTRL_LOW_FIXED};
   end

   // register file next state; bit 0 of the base is never stored
   always_comb begin
      legacy_base_next          = legacy_base_reg;
      irq_slot_shift_next       = irq_slot_shift_reg;
      merge_int_lines_next      = merge_int_lines_reg;
      switch_clock_dir_next     = switch_clock_dir_reg;
      power_event_route_next    = power_event_route_reg;
      power_write_irq_en_next   = power_write_irq_en_reg;
      spare_terminal_drive_next = spare_terminal_drive_reg;
      reduced_video_next        = reduced_video_reg;
      card_dma_req_en_next      = card_dma_req_en_reg;
      dma_channel_sel_next      = dma_channel_sel_reg;
      supply_guard_off_next     = supply_guard_off_reg;
      power_write_flag_next     = power_write_flag_reg;
      if (wr_base) begin
         if (cfg_byte_en_i[0]) legacy_base_next[7:1]   = cfg_wdata_i[7:1];
         if (cfg_byte_en_i[1]) legacy_base_next[15:8]  = cfg_wdata_i[15:8];
         if (cfg_byte_en_i[2]) legacy_base_next[23:16] = cfg_wdata_i[23:16];
         if (cfg_byte_en_i[3]) legacy_base_next[31:24] = cfg_wdata_i[31:24];
      end
      // global bits accepted from either function; software uses function 0
      if (wr_ctrl && cfg_byte_en_i[3]) begin
         irq_slot_shift_next     = cfg_wdata_i[`IRQ_SLOT_SHIFT_HI:`IRQ_SLOT_SHIFT_LO];
         merge_int_lines_next    = cfg_wdata_i[`MERGE_INT_LINES_BIT];
         switch_clock_dir_next   = cfg_wdata_i[`SWITCH_CLOCK_DIR_BIT];
         power_event_route_next  = cfg_wdata_i[`POWER_EVENT_ROUTE_BIT];
         power_write_irq_en_next = cfg_wdata_i[`POWER_WRITE_IRQ_EN_BIT];
         if (cfg_wdata_i[`POWER_WRITE_FLAG_BIT]) begin
            power_write_flag_next[cfg_func_i] = 1'b0;
         end
      end
      if (wr_ctrl && cfg_byte_en_i[2]) begin
         spare_terminal_drive_next         = cfg_wdata_i[`SPARE_TERM_DRIVE_BIT];
         supply_guard_off_next[cfg_func_i] = cfg_wdata_i[`SUPPLY_GUARD_OFF_BIT];
         reduced_video_next                = cfg_wdata_i[`REDUCED_VIDEO_BIT];
         card_dma_req_en_next              = cfg_wdata_i[`CARD_DMA_REQ_EN_BIT];
         dma_channel_sel_next              = cfg_wdata_i[`DMA_CHANNEL_HI:`DMA_CHANNEL_LO];
      end
      // low half, bits 28 and 23 and base bit 0 have no storage at all
      // a power write in the clearing cycle still sets: set wins
      if (power_write_irq_en_reg) begin
         power_write_flag_next = power_write_flag_next | power_write_i;
      end
   end

   // access answer one cycle after the request
   always_comb begin
      cfg_ack_next   = cfg_req_i;
      cfg_rdata_next = 32'h0000_0000;
      if (cfg_req_i && !cfg_write_i) begin
         if (hit_base) begin
            cfg_rdata_next = {legacy_base_reg, 1'b1};
         end else if (hit_ctrl) begin
            cfg_rdata_next = ctrl_view;
         end
      end
   end

   // global reset is the only reset that loads the field reset values
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         legacy_base_reg          <= 31'h0000_0000;
         irq_slot_shift_reg       <= 2'h0;
         merge_int_lines_reg      <= 1'b0;
         switch_clock_dir_reg     <= 1'b0;
         power_event_route_reg    <= 1'b0;
         power_write_irq_en_reg   <= 1'b0;
         spare_terminal_drive_reg <= 1'b1;
         reduced_video_reg        <= 1'b0;
         card_dma_req_en_reg      <= 1'b0;
         dma_channel_sel_reg      <= `DMA_CHANNEL_UNUSED;
         supply_guard_off_reg     <= 2'h0;
         power_write_flag_reg     <= 2'h0;
         cfg_ack_reg              <= 1'b0;
         cfg_rdata_reg            <= 32'h0000_0000;
      end else begin
         legacy_base_reg          <= legacy_base_next;
         irq_slot_shift_reg       <= irq_slot_shift_next;
         merge_int_lines_reg      <= merge_int_lines_next;
         switch_clock_dir_reg     <= switch_clock_dir_next;
         power_event_route_reg    <= power_event_route_next;
         power_write_irq_en_reg   <= power_write_irq_en_next;
         spare_terminal_drive_reg <= spare_terminal_drive_next;
         reduced_video_reg        <= reduced_video_next;
         card_dma_req_en_reg      <= card_dma_req_en_next;
         dma_channel_sel_reg      <= dma_channel_sel_next;
         supply_guard_off_reg     <= supply_guard_off_next;
         power_write_flag_reg     <= power_write_flag_next;
         cfg_ack_reg              <= cfg_ack_next;
         cfg_rdata_reg            <= cfg_rdata_next;
      end
   end

   // two flops on every socket pin before use
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         inserted_meta_reg <= 2'h0;
         inserted_sync_reg <= 2'h0;
         request_meta_reg  <= 2'h0;
         request_sync_reg  <= 2'h0;
      end else begin
         inserted_meta_reg <= card_inserted_i;
         inserted_sync_reg <= inserted_meta_reg;
         request_meta_reg  <= card_dma_request_i;
         request_sync_reg  <= request_meta_reg;
      end
   end

   // index and data addresses; bit 0 is forced low for the index, high for the data
   assign index_addr = {legacy_base_reg, 1'b0};
   assign data_addr  = {legacy_base_reg, 1'b1};

   // behaviour steered by the fields, registered onto the outputs
   always_comb begin
      logic ia;
      logic ib;
      ia = int_a_i | (merge_int_lines_reg & int_b_i);
      ib = int_b_i & ~merge_int_lines_reg;
      index_hit_next = io_valid_i && (io_addr_i == index_addr);
      data_hit_next  = io_valid_i && (io_addr_i == data_addr);
      // events only leave the block while interrupts are enabled
      irq2_next = power_write_irq_en_reg & ~power_event_route_reg & (|power_write_i);
      change_next = {2{power_write_irq_en_reg & power_event_route_reg}} & power_write_i;
      // slot order in the vector: [0]=A [1]=B [2]=C [3]=D
      unique case (step)
         STEP_B_C:   serial_irq_next = {1'b0, ib, ia, 1'b0};
         STEP_C_D,
         STEP_C_D_2: serial_irq_next = {ib, ia, 1'b0, 1'b0};
         STEP_D_A:   serial_irq_next = {ia, 1'b0, 1'b0, ib};
      endcase
      clock_oe_n_next   = ~switch_clock_dir_reg;
      // terminals float unless a card sits in the socket
      spare_oe_n_next   = ~({2{spare_terminal_drive_reg}} & inserted_sync_reg);
      guard_en_next     = ~supply_guard_off_reg;
      addr_oe_n_next    = reduced_video_reg;
      // code 4 names the bus master and never carries a card request
      dma_req_next      = {2{card_dma_req_en_reg && (dma_channel_sel_reg != `DMA_CHANNEL_UNUSED)}}
                          & request_sync_reg;
      dma_chan_out_next = dma_channel_sel_reg;
   end

   // output flops
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         index_hit_reg    <= 1'b0;
         data_hit_reg     <= 1'b0;
         irq2_reg         <= 1'b0;
         change_reg       <= 2'h0;
         serial_irq_reg   <= 4'h0;
         clock_oe_n_reg   <= 1'b1;
         spare_oe_n_reg   <= 2'h3;
         guard_en_reg     <= 2'h3;
         addr_oe_n_reg    <= 1'b0;
         dma_req_reg      <= 2'h0;
         dma_chan_out_reg <= `DMA_CHANNEL_UNUSED;
      end else begin
         index_hit_reg    <= index_hit_next;
         data_hit_reg     <= data_hit_next;
         irq2_reg         <= irq2_next;
         change_reg       <= change_next;
         serial_irq_reg   <= serial_irq_next;
         clock_oe_n_reg   <= clock_oe_n_next;
         spare_oe_n_reg   <= spare_oe_n_next;
         guard_en_reg     <= guard_en_next;
         addr_oe_n_reg    <= addr_oe_n_next;
         dma_req_reg      <= dma_req_next;
         dma_chan_out_reg <= dma_chan_out_next;
      end
   end

   assign cfg_ack_o              = cfg_ack_reg;
   assign cfg_rdata_o            = cfg_rdata_reg;
   assign legacy_index_hit_o     = index_hit_reg;
   assign legacy_data_hit_o      = data_hit_reg;
   assign legacy_irq2_o          = irq2_reg;
   assign card_status_change_o   = change_reg;
   assign serial_irq_line_o      = serial_irq_reg;
   assign switch_clock_oe_n_o    = clock_oe_n_reg;
   assign spare_terminals_oe_n_o = spare_oe_n_reg;
   assign supply_guard_en_o      = guard_en_reg;
   assign card_addr_hi_oe_n_o    = addr_oe_n_reg;
   assign dma_request_o          = dma_req_reg;
   assign dma_channel_sel_o      = dma_chan_out_reg;

endmodule : card_bridge_system_config
`default_nettype wire

// [verification/card_bridge_system_config_monitor.sv]
// port-level assertion checker for the card bridge system configuration block
`timescale 1ns/1ps
`default_nettype none

module card_bridge_system_config_monitor (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic        cfg_req_i,
   input wire logic        cfg_ack_o,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic        io_valid_i,
   input wire logic        legacy_index_hit_o,
   input wire logic        legacy_data_hit_o,
   input wire logic [1:0]  power_write_i,
   input wire logic        legacy_irq2_o,
   input wire logic [1:0]  card_status_change_o,
   input wire logic        int_a_i,
   input wire logic        int_b_i,
   input wire logic [3:0]  serial_irq_line_o,
   input wire logic [1:0]  dma_request_o,
   input wire logic [2:0]  dma_channel_sel_o
);
   // one clock domain, so clock and reset are given once for all
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   // every access is answered exactly one edge later, even unmapped ones
   a_ack_follows_req: assert property (cfg_req_i |=> cfg_ack_o)
      else $error("access not acknowledged");
   a_no_stray_ack: assert property (!cfg_req_i |=> !cfg_ack_o)
      else $error("acknowledge without access");
   a_rdata_idle_zero: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
      else $error("read data not zero outside acknowledge");
   // decode hits need an io cycle one edge earlier
   a_index_hit_cause: assert property (legacy_index_hit_o |-> $past(io_valid_i) && !legacy_data_hit_o)
      else $error("index hit without io cycle");
   a_data_hit_cause: assert property (legacy_data_hit_o |-> $past(io_valid_i))
      else $error("data hit without io cycle");
   // route picks one of the two outputs, never both
   a_irq2_cause: assert property (legacy_irq2_o |-> $past(|power_write_i) && card_status_change_o == 2'h0)
      else $error("irq2 pulse without power write");
   a_status_change_cause: assert property (|card_status_change_o |->
      (card_status_change_o & ~$past(power_write_i)) == 2'h0)
      else $error("status change on a socket without power write");
   a_serial_cause: assert property (serial_irq_line_o != 4'h0 |-> $past(int_a_i || int_b_i))
      else $error("serial slot active without interrupt");
   a_dma_channel_block: assert property (dma_channel_sel_o == 3'h4 && $past(dma_channel_sel_o) == 3'h4
      |-> dma_request_o == 2'h0)
      else $error("dma request forwarded on unused channel");
endmodule : card_bridge_system_config_monitor

bind card_bridge_system_config card_bridge_system_config_monitor mon (.clock_i, .reset_i, .cfg_req_i,
   .cfg_ack_o, .cfg_rdata_o, .io_valid_i, .legacy_index_hit_o, .legacy_data_hit_o, .power_write_i,
   .legacy_irq2_o, .card_status_change_o, .int_a_i, .int_b_i, .serial_irq_line_o, .dma_request_o,
   .dma_channel_sel_o);
`default_nettype wire

// [verification/card_bridge_system_config_tb.sv]
// self-checking bench for the card bridge system configuration registers
`timescale 1ns/1ps
`default_nettype none

module card_bridge_system_config_tb import card_bridge_pkg::*;;
   logic        clock_i = 1'b0, reset_i = 1'b1, cfg_req_i = 1'b0, cfg_write_i = 1'b0;
   cfg_func_t   cfg_func_i = '0;
   logic [7:0]  cfg_addr_i = 8'h00;
   logic [3:0]  cfg_byte_en_i = 4'h0, serial_irq_line_o;
   logic [31:0] cfg_wdata_i = 32'h0, io_addr_i = 32'h0, cfg_rdata_o, rd;
   logic        io_valid_i = 1'b0, int_a_i = 1'b0, int_b_i = 1'b0;
   logic [1:0]  power_write_i = 2'h0, card_inserted_i = 2'h0, card_dma_request_i = 2'h0;
   logic        cfg_ack_o, legacy_index_hit_o, legacy_data_hit_o, legacy_irq2_o;
   logic        switch_clock_oe_n_o, card_addr_hi_oe_n_o;
   logic [1:0]  card_status_change_o, spare_terminals_oe_n_o, supply_guard_en_o, dma_request_o;
   logic [2:0]  dma_channel_sel_o;
   int          bad_count = 0, samples_checked = 0;

   // 125 MHz clock
   always #4 clock_i = ~clock_i;

   card_bridge_system_config dut (.clock_i, .reset_i, .cfg_req_i, .cfg_write_i, .cfg_func_i, .cfg_addr_i,
      .cfg_byte_en_i, .cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o, .io_valid_i, .io_addr_i, .legacy_index_hit_o,
      .legacy_data_hit_o, .power_write_i, .legacy_irq2_o, .card_status_change_o, .int_a_i, .int_b_i,
      .serial_irq_line_o, .card_inserted_i, .card_dma_request_i, .switch_clock_oe_n_o,
      .spare_terminals_oe_n_o, .supply_guard_en_o, .card_addr_hi_oe_n_o, .dma_request_o, .dma_channel_sel_o);

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle request pulse, then a bounded wait for the acknowledge
   task automatic xfer(input logic wr, input cfg_func_t f, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
      int n;
      @(posedge clock_i);
      cfg_req_i <= 1'b1;
      cfg_write_i <= wr;
      cfg_func_i <= f;
      cfg_addr_i <= a;
      cfg_byte_en_i <= be;
      cfg_wdata_i <= d;
      @(posedge clock_i);
      cfg_req_i <= 1'b0;
      n = 0;
      #1;
      while (cfg_ack_o !== 1'b1 && n < 4) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      rd = cfg_rdata_o;
      if (n == 4) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, cfg_ack_o, 1'b1);
         give_verdict();
      end
   endtask : xfer

   task automatic rdchk(input cfg_func_t f, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, f, a, 4'hf, 32'h0);
      chk(rd, e);
   endtask : rdchk

   // socket pin inputs pass a two-flop synchroniser, so allow a few edges
   task automatic pins(input logic [10:0] e);
      repeat (4) @(posedge clock_i);
      #1;
      chk({switch_clock_oe_n_o, spare_terminals_oe_n_o, supply_guard_en_o, card_addr_hi_oe_n_o,
           dma_channel_sel_o, dma_request_o}, e);
   endtask : pins

   // pulses are caught over two edges so their exact edge does not matter
   task automatic pwr(input logic [1:0] s, input logic ei, input logic [1:0] ec);
      logic [2:0] seen;
      seen = 3'h0;
      @(posedge clock_i);
      power_write_i <= s;
      @(posedge clock_i);
      power_write_i <= 2'h0;
      repeat (2) begin
         #1;
         seen |= {legacy_irq2_o, card_status_change_o};
         @(posedge clock_i);
      end
      chk(seen, {ei, ec});
   endtask : pwr

   task automatic io(input logic [31:0] a, input logic [1:0] e);
      logic [1:0] seen;
      seen = 2'h0;
      @(posedge clock_i);
      io_valid_i <= 1'b1;
      io_addr_i <= a;
      @(posedge clock_i);
      io_valid_i <= 1'b0;
      repeat (2) begin
         #1;
         seen |= {legacy_index_hit_o, legacy_data_hit_o};
         @(posedge clock_i);
      end
      chk(seen, e);
   endtask : io

   task automatic ser(input logic a, input logic b, input logic [3:0] e);
      @(posedge clock_i);
      int_a_i <= a;
      int_b_i <= b;
      repeat (2) @(posedge clock_i);
      #1;
      chk(serial_irq_line_o, e);
   endtask : ser

   // main sequence
   initial begin
      int a;
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      pins({1'b1, 2'h3, 2'h3, 1'b0, 3'h4, 2'h0});
      rdchk(1'b0, 8'h44, 32'h0000_0001);
      rdchk(1'b1, 8'h80, 32'h0044_9060);
      rdchk(1'b0, 8'h10, 32'h0);
      xfer(1'b1, 1'b0, 8'h44, 4'hf, 32'hffff_ffff);
      rdchk(1'b1, 8'h44, 32'hffff_ffff);
      xfer(1'b1, 1'b1, 8'h44, 4'hf, 32'h1234_5678);
      rdchk(1'b0, 8'h44, 32'h1234_5679);
      io(32'h1234_5678, 2'h2);
      io(32'h1234_5679, 2'h1);
      io(32'h1234_567a, 2'h0);
      // global bits are only ever written through function 0
      xfer(1'b1, 1'b0, 8'h80, 4'hf, 32'hffff_ffff);
      rdchk(1'b0, 8'h80, 32'hed7f_9060);
      rdchk(1'b1, 8'h80, 32'hed5f_9060);
      pins({1'b0, 2'h3, 2'h2, 1'b1, 3'h7, 2'h0});
      @(posedge clock_i);
      card_inserted_i <= 2'h3;
      card_dma_request_i <= 2'h1;
      pins({1'b0, 2'h0, 2'h2, 1'b1, 3'h7, 2'h1});
      pwr(2'h1, 1'b0, 2'h1);
      rdchk(1'b0, 8'h80, 32'hef7f_9060);
      xfer(1'b1, 1'b0, 8'h80, 4'h8, 32'hef00_0000);
      rdchk(1'b0, 8'h80, 32'hed7f_9060);
      xfer(1'b1, 1'b0, 8'h80, 4'h8, 32'he900_0000);
      pwr(2'h2, 1'b1, 2'h0);
      rdchk(1'b1, 8'h80, 32'heb5f_9060);
      xfer(1'b1, 1'b0, 8'h80, 4'h8, 32'he800_0000);
      pwr(2'h3, 1'b0, 2'h0);
      rdchk(1'b0, 8'h80, 32'he87f_9060);
      xfer(1'b1, 1'b0, 8'h80, 4'h4, 32'h007c_0000);
      pins({1'b0, 2'h0, 2'h2, 1'b1, 3'h4, 2'h0});
      xfer(1'b1, 1'b0, 8'h80, 4'h4, 32'h0077_0000);
      pins({1'b0, 2'h0, 2'h2, 1'b1, 3'h7, 2'h0});
      xfer(1'b1, 1'b0, 8'h80, 4'h4, 32'h002f_0000);
      pins({1'b0, 2'h3, 2'h2, 1'b0, 3'h7, 2'h1});
      // every step code, with and without the tie
      for (int c = 0; c < 4; c++) begin
         a = (c == 0) ? 1 : (c == 3) ? 3 : 2;
         xfer(1'b1, 1'b0, 8'h80, 4'h8, {c[1:0], 30'h0});
         ser(1'b1, 1'b1, (4'h1 << a) | (4'h1 << ((a + 1) % 4)));
         xfer(1'b1, 1'b0, 8'h80, 4'h8, {c[1:0], 1'b1, 29'h0});
         ser(1'b0, 1'b1, 4'h1 << a);
      end
      // a second global reset restores the documented values
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      rdchk(1'b0, 8'h80, 32'h0044_9060);
      rdchk(1'b1, 8'h44, 32'h0000_0001);
      give_verdict();
   end
endmodule : card_bridge_system_config_tb
`default_nettype wire
